// ==== rtl/ccsce_defs.svh ====
`ifndef CCSCE_DEFS_SVH
`define CCSCE_DEFS_SVH
`define CCSCE_CLA_APP 8'hA0
`define CCSCE_INS_SELECT 8'hA4
`define CCSCE_INS_STATUS 8'hF2
`define CCSCE_INS_READ_BIN 8'hB0
`define CCSCE_INS_UPD_BIN 8'hD6
`define CCSCE_INS_READ_REC 8'hB2
`define CCSCE_INS_UPD_REC 8'hDC
`define CCSCE_INS_SEEK 8'hA2
`define CCSCE_INS_INCREASE 8'h32
`define CCSCE_INS_VERIFY 8'h20
`define CCSCE_INS_CHANGE 8'h24
`define CCSCE_INS_DISABLE 8'h26
`define CCSCE_INS_ENABLE 8'h28
`define CCSCE_INS_UNBLOCK 8'h2C
`define CCSCE_INS_INVALIDATE 8'h04
`define CCSCE_INS_REHAB 8'h44
`define CCSCE_INS_RUN_AUTH 8'h88
`define CCSCE_INS_SLEEP 8'hFA
`define CCSCE_INS_GET_RESP 8'hC0
`define CCSCE_P3_CODE 8'h08
`define CCSCE_P3_CODE_PAIR 8'h10
`define CCSCE_P3_AUTH 8'h10
`define CCSCE_P3_NONE 8'h00
`define CCSCE_P2_FIRST 8'h01
`define CCSCE_P2_SECOND 8'h02
`define CCSCE_P2_UNBLK_FIRST 8'h00
`define CCSCE_P2_UNBLK_SECOND 8'h02
`define CCSCE_CODE_TRIES 4'h3
`define CCSCE_UNBLK_TRIES 4'hA
`define CCSCE_AUTH_RESP_LEN 8'h0C
`define CCSCE_SW_OK 16'h9000
`define CCSCE_SW1_PENDING 8'h9F
`define CCSCE_SW_BAD_CLASS 16'h6E00
`define CCSCE_SW_BAD_INS 16'h6D00
`define CCSCE_SW_BAD_LEN 16'h6700
`define CCSCE_SW_BAD_P12 16'h6B00
`define CCSCE_SW_NO_ACCESS 16'h9804
`define CCSCE_SW_STATE 16'h9808
`define CCSCE_SW_BLOCKED 16'h9840
`define CCSCE_SW_INVALID 16'h9810
`define CCSCE_SW_NO_FILE 16'h9400
`define CCSCE_ADDR_CMD 12'h000
`define CCSCE_ADDR_DATA_LO 12'h004
`define CCSCE_ADDR_DATA_HI 12'h008
`define CCSCE_ADDR_CTRL 12'h00C
`define CCSCE_ADDR_STATUS 12'h010
`define CCSCE_ADDR_SW 12'h014
`define CCSCE_ADDR_RESP_LO 12'h018
`define CCSCE_ADDR_RESP_HI 12'h01C
`define CCSCE_ADDR_RESP_W2 12'h020
`endif

// ==== rtl/ccsce_pkg.sv ====
package ccsce_pkg;
  typedef struct packed {
    logic [7:0] cla;
    logic [7:0] ins;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] p3;
  } ccsce_hdr_type;
  typedef logic [127:0] ccsce_data_type;
  typedef logic [95:0] ccsce_resp_type;
endpackage

// ==== rtl/ccsce_if.sv ====
`timescale 1ns/100ps
interface ccsce_if;
  import ccsce_pkg::*;
  logic cmd_valid;
  logic cmd_ready;
  ccsce_hdr_type hdr;
  ccsce_data_type cmd_data;
  logic rsp_valid;
  logic [15:0] sw;
  ccsce_resp_type rsp_data;
  logic [7:0] rsp_len;
  modport card (input cmd_valid, hdr, cmd_data, output cmd_ready, rsp_valid, sw, rsp_data,
    rsp_len);
  modport handset (output cmd_valid, hdr, cmd_data, input cmd_ready, rsp_valid, sw, rsp_data,
    rsp_len);
endinterface

// ==== rtl/ccsce_card.sv ====
`timescale 1ns/100ps
`include "ccsce_defs.svh"
// Summary of operation
// - disable only first code, not disabled/blocked
// - good disable: counter to 3, disabled
// - bad code decrements; zero tries blocks code
// - enable mirrors disable, refused if enabled/blocked
// - unblock accepted whether or not blocked
// - good unblock stores code, reloads, enables
// - bad unblock decrements key, code untouched
// - invalidate needs access, sets file flag
// - invalidated file rejects only binary/record access, seek, increase and invalidate
// - rehabilitate needs access, clears file flag
// - auth needs app directory and first code verified or disabled
// - handset never sends obsolete sleep
// - header five bytes, status two, class A0
// - P3 zero is 256 out, none in; get response refuses P3 zero with 6700
// - FF is valid parameter byte value
// - pending reply answers 9F with length
// - success reports status 9000
// - foreign class changes no state
// - binary offset is P1 high, P2 low
// - reserved instruction codes never decoded
// - fixed instruction codes and lengths
// - code command lengths and code numbers
// - verify reloads or decrements try counter
module ccsce_card
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link to handset
  ccsce_if.card link,
  // file and application context
  input wire logic app_dir_current,
  input wire logic file_selected,
  input wire logic file_access_ok,
  input wire logic [63:0] first_code_init,
  input wire logic [63:0] second_code_init,
  input wire logic [63:0] unblock_key_first,
  input wire logic [63:0] unblock_key_second,
  input wire ccsce_pkg::ccsce_resp_type auth_result,
  // status seen by the card core
  output logic first_code_enabled,
  output logic first_code_verified,
  output logic file_invalidated,
  output logic [15:0] binary_offset
);
  import ccsce_pkg::*;
  logic [63:0] code_ff [2];
  logic [3:0] tries_ff [2], unblk_tries_ff [2];
  logic [1:0] verified_ff;
  logic code1_disabled_ff, loaded_ff, inval_ff, rsp_valid_ff;
  logic [7:0] pend_len_ff, rsp_len_ff;
  logic [15:0] sw_ff, offset_ff;
  ccsce_resp_type rsp_data_ff;
  ccsce_hdr_type h;
  logic idx, code_ok, unblk_ok, blocked;
  logic [15:0] nxt_sw;
  logic [1:0] do_code;
  logic do_unblock, do_able, do_file, do_auth, do_getresp, do_binary;
  assign h = link.hdr;
  assign link.cmd_ready = 1'b1;
  assign idx = (h.ins == `CCSCE_INS_UNBLOCK) ? (h.p2 == `CCSCE_P2_UNBLK_SECOND)
    : (h.p2 == `CCSCE_P2_SECOND);
  assign code_ok = (link.cmd_data[127:64] == code_ff[idx]);
  assign unblk_ok = (link.cmd_data[127:64] == (idx ? unblock_key_second : unblock_key_first));
  assign blocked = (tries_ff[idx] == 4'h0);
  // decode, checks, status word
  always_comb
  begin
    nxt_sw = `CCSCE_SW_OK;
    do_code = 2'b00;
    do_unblock = 1'b0;
    do_able = 1'b0;
    do_file = 1'b0;
    do_auth = 1'b0;
    do_getresp = 1'b0;
    do_binary = 1'b0;
    if (h.cla != `CCSCE_CLA_APP)
      nxt_sw = `CCSCE_SW_BAD_CLASS;
    else
    begin
      case (h.ins)
        `CCSCE_INS_VERIFY, `CCSCE_INS_CHANGE:
        begin
          if (h.p3 != `CCSCE_P3_CODE && !(h.ins == `CCSCE_INS_CHANGE
              && h.p3 == `CCSCE_P3_CODE_PAIR))
            nxt_sw = `CCSCE_SW_BAD_LEN;
          else if (h.p2 != `CCSCE_P2_FIRST && h.p2 != `CCSCE_P2_SECOND)
            nxt_sw = `CCSCE_SW_BAD_P12;
          else if (!idx && code1_disabled_ff)
            nxt_sw = `CCSCE_SW_STATE;
          else if (blocked)
            nxt_sw = `CCSCE_SW_BLOCKED;
          else
          begin
            do_code[idx] = 1'b1;
            nxt_sw = code_ok ? `CCSCE_SW_OK : `CCSCE_SW_NO_ACCESS;
          end
        end
        `CCSCE_INS_DISABLE, `CCSCE_INS_ENABLE:
        begin
          if (h.p3 != `CCSCE_P3_CODE)
            nxt_sw = `CCSCE_SW_BAD_LEN;
          else if (h.p2 != `CCSCE_P2_FIRST)
            nxt_sw = `CCSCE_SW_BAD_P12;
          else if (tries_ff[0] == 4'h0)
            nxt_sw = `CCSCE_SW_BLOCKED;
          else if ((h.ins == `CCSCE_INS_DISABLE) == code1_disabled_ff)
            nxt_sw = `CCSCE_SW_STATE;
          else
          begin
            do_able = 1'b1;
            nxt_sw = code_ok ? `CCSCE_SW_OK : `CCSCE_SW_NO_ACCESS;
          end
        end
        `CCSCE_INS_UNBLOCK:
        begin
          if (h.p3 != `CCSCE_P3_CODE_PAIR)
            nxt_sw = `CCSCE_SW_BAD_LEN;
          else if (h.p2 != `CCSCE_P2_UNBLK_FIRST && h.p2 != `CCSCE_P2_UNBLK_SECOND)
            nxt_sw = `CCSCE_SW_BAD_P12;
          else if (unblk_tries_ff[idx] == 4'h0)
            nxt_sw = `CCSCE_SW_BLOCKED;
          else
          begin
            do_unblock = 1'b1;
            nxt_sw = unblk_ok ? `CCSCE_SW_OK : `CCSCE_SW_NO_ACCESS;
          end
        end
        `CCSCE_INS_INVALIDATE, `CCSCE_INS_REHAB:
        begin
          if (h.p3 != `CCSCE_P3_NONE)
            nxt_sw = `CCSCE_SW_BAD_LEN;
          else if (!file_selected)
            nxt_sw = `CCSCE_SW_NO_FILE;
          else if (!file_access_ok)
            nxt_sw = `CCSCE_SW_NO_ACCESS;
          else if (inval_ff && h.ins == `CCSCE_INS_INVALIDATE)
            nxt_sw = `CCSCE_SW_INVALID;
          else
            do_file = 1'b1;
        end
        `CCSCE_INS_RUN_AUTH:
        begin
          if (h.p3 != `CCSCE_P3_AUTH)
            nxt_sw = `CCSCE_SW_BAD_LEN;
          else if (!app_dir_current || !(code1_disabled_ff || verified_ff[0]))
            nxt_sw = `CCSCE_SW_NO_ACCESS;
          else
          begin
            do_auth = 1'b1;
            nxt_sw = {`CCSCE_SW1_PENDING, `CCSCE_AUTH_RESP_LEN};
          end
        end
        `CCSCE_INS_GET_RESP:
        begin
          if (pend_len_ff == 8'h00 || h.p3 == 8'h00 || h.p3 > pend_len_ff)
            nxt_sw = `CCSCE_SW_BAD_LEN;
          else
            do_getresp = 1'b1;
        end
        `CCSCE_INS_READ_BIN, `CCSCE_INS_UPD_BIN, `CCSCE_INS_READ_REC,
        `CCSCE_INS_UPD_REC, `CCSCE_INS_SEEK, `CCSCE_INS_INCREASE:
        begin
          if (inval_ff)
            nxt_sw = `CCSCE_SW_INVALID;
          else
            do_binary = (h.ins == `CCSCE_INS_READ_BIN || h.ins == `CCSCE_INS_UPD_BIN);
        end
        `CCSCE_INS_SELECT, `CCSCE_INS_STATUS:
          nxt_sw = `CCSCE_SW_OK;
        default:
          nxt_sw = `CCSCE_SW_BAD_INS;
      endcase
    end
  end
  // code values and try counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      loaded_ff <= 1'b0;
      code_ff[0] <= 64'h0;
      code_ff[1] <= 64'h0;
      tries_ff[0] <= `CCSCE_CODE_TRIES;
      tries_ff[1] <= `CCSCE_CODE_TRIES;
      unblk_tries_ff[0] <= `CCSCE_UNBLK_TRIES;
      unblk_tries_ff[1] <= `CCSCE_UNBLK_TRIES;
      code1_disabled_ff <= 1'b0;
      verified_ff <= 2'b00;
    end
    else if (!loaded_ff)
    begin
      loaded_ff <= 1'b1;
      code_ff[0] <= first_code_init;
      code_ff[1] <= second_code_init;
    end
    else if (link.cmd_valid)
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (do_code[i])
        begin
          tries_ff[i] <= code_ok ? `CCSCE_CODE_TRIES : tries_ff[i] - 4'h1;
          verified_ff[i] <= code_ok;
          if (code_ok && h.ins == `CCSCE_INS_CHANGE)
            code_ff[i] <= link.cmd_data[63:0];
        end
      end
      if (do_able)
      begin
        tries_ff[0] <= code_ok ? `CCSCE_CODE_TRIES : tries_ff[0] - 4'h1;
        if (code_ok)
          code1_disabled_ff <= (h.ins == `CCSCE_INS_DISABLE);
      end
      if (do_unblock)
      begin
        if (unblk_ok)
        begin
          code_ff[idx] <= link.cmd_data[63:0];
          unblk_tries_ff[idx] <= `CCSCE_UNBLK_TRIES;
          tries_ff[idx] <= `CCSCE_CODE_TRIES;
          verified_ff[idx] <= 1'b1;
          if (!idx)
            code1_disabled_ff <= 1'b0;
        end
        else
          unblk_tries_ff[idx] <= unblk_tries_ff[idx] - 4'h1;
      end
    end
  end
  // reply, deferred data and file status
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rsp_valid_ff <= 1'b0;
      sw_ff <= 16'h0000;
      rsp_data_ff <= '0;
      rsp_len_ff <= 8'h00;
      pend_len_ff <= 8'h00;
      inval_ff <= 1'b0;
      offset_ff <= 16'h0000;
    end
    else
    begin
      rsp_valid_ff <= link.cmd_valid;
      if (link.cmd_valid)
      begin
        sw_ff <= nxt_sw;
        rsp_len_ff <= do_getresp ? h.p3 : 8'h00;
        if (do_auth)
          rsp_data_ff <= auth_result;
        if (do_auth || (h.cla == `CCSCE_CLA_APP && !do_getresp))
          pend_len_ff <= do_auth ? `CCSCE_AUTH_RESP_LEN : 8'h00;
        if (do_file)
          inval_ff <= (h.ins == `CCSCE_INS_INVALIDATE);
        if (do_binary)
          offset_ff <= {h.p1, h.p2};
      end
    end
  end
  assign link.rsp_valid = rsp_valid_ff;
  assign link.sw = sw_ff;
  assign link.rsp_data = rsp_data_ff;
  assign link.rsp_len = rsp_len_ff;
  assign first_code_enabled = !code1_disabled_ff;
  assign first_code_verified = verified_ff[0];
  assign file_invalidated = inval_ff;
  assign binary_offset = offset_ff;
endmodule

// ==== rtl/ccsce_handset.sv ====
`timescale 1ns/100ps
`include "ccsce_defs.svh"
module ccsce_handset
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link to card
  ccsce_if.handset link
);
  import ccsce_pkg::*;

  logic [31:0] cmd_ff;
  logic [7:0] p3_ff;
  logic [127:0] data_ff;
  logic busy_ff;
  logic done_ff;
  logic [15:0] sw_ff;
  ccsce_resp_type resp_ff;
  logic [7:0] rlen_ff;
  logic wr;
  logic rd;
  logic go;
  logic sleep_req;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  // obsolete sleep instruction is never sent
  assign sleep_req = (cmd_ff[23:16] == `CCSCE_INS_SLEEP);
  assign go = wr && paddr == `CCSCE_ADDR_CTRL && pwdata[0] && !busy_ff && !sleep_req;

  // command registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_ff <= {`CCSCE_CLA_APP, 24'h000000};
      p3_ff <= 8'h00;
      data_ff <= '0;
    end
    else if (wr && !busy_ff)
    begin
      case (paddr)
        `CCSCE_ADDR_CMD: cmd_ff <= pwdata;
        `CCSCE_ADDR_DATA_LO: data_ff[63:0] <= {data_ff[31:0], pwdata};
        `CCSCE_ADDR_DATA_HI: data_ff[127:64] <= {data_ff[95:64], pwdata};
        `CCSCE_ADDR_CTRL: p3_ff <= pwdata[15:8];
        default: ;
      endcase
    end
  end

  // link request and reply capture
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      sw_ff <= 16'h0000;
      resp_ff <= '0;
      rlen_ff <= 8'h00;
    end
    else
    begin
      if (go)
      begin
        busy_ff <= 1'b1;
        done_ff <= 1'b0;
      end
      else if (busy_ff && link.rsp_valid)
      begin
        busy_ff <= 1'b0;
        done_ff <= 1'b1; // set wins over read clear
        sw_ff <= link.sw;
        rlen_ff <= link.rsp_len;
        if (link.rsp_len != 8'h00)
          resp_ff <= link.rsp_data;
      end
      else if (rd && paddr == `CCSCE_ADDR_SW)
        done_ff <= 1'b0;
    end
  end

  assign link.cmd_valid = busy_ff && !link.rsp_valid && link.cmd_ready;
  assign link.hdr = {cmd_ff, p3_ff};
  assign link.cmd_data = data_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        `CCSCE_ADDR_CMD: prdata <= cmd_ff;
        `CCSCE_ADDR_CTRL: prdata <= {16'h0000, p3_ff, 8'h00};
        `CCSCE_ADDR_STATUS: prdata <= {24'h000000, rlen_ff[5:0], done_ff, busy_ff};
        `CCSCE_ADDR_SW: prdata <= {16'h0000, sw_ff};
        `CCSCE_ADDR_RESP_LO: prdata <= resp_ff[31:0];
        `CCSCE_ADDR_RESP_HI: prdata <= resp_ff[63:32];
        `CCSCE_ADDR_RESP_W2: prdata <= resp_ff[95:64];
        default: prdata <= 32'h00000000;
      endcase
    end
  end
endmodule

// ==== test/ccsce_checker.sv ====
`timescale 1ns/100ps
module ccsce_checker
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link signals
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire ccsce_pkg::ccsce_hdr_type hdr,
  input wire ccsce_pkg::ccsce_data_type cmd_data,
  input wire logic rsp_valid,
  input wire logic [15:0] sw,
  input wire ccsce_pkg::ccsce_resp_type rsp_data,
  input wire logic [7:0] rsp_len
);
  import ccsce_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic app_cmd;
  logic rsvd;
  assign app_cmd = cmd_valid && hdr.cla == 8'hA0;
  // operational and administrative reserved codes
  assign rsvd = (hdr.ins[7:4] == 4'h1 && !hdr.ins[0]) ||
    hdr.ins inside {8'h2A, 8'hD0, 8'hD2, 8'hDE, 8'hC4, 8'hC6, 8'hC8, 8'hCA, 8'hCC,
    8'hB4, 8'hB6, 8'hB8, 8'hBA, 8'hBC};
  a_answer_next: assert property (cmd_valid |=> rsp_valid)
    else $error("no answer after command");
  a_answer_pulse: assert property (rsp_valid |-> !cmd_valid ##1 !rsp_valid)
    else $error("answer not a single pulse");
  a_foreign_class: assert property (cmd_valid && hdr.cla != 8'hA0 |=> sw == 16'h6E00)
    else $error("foreign class not refused");
  a_reserved_ins: assert property (app_cmd && rsvd |=> sw == 16'h6D00)
    else $error("reserved code decoded");
  a_no_sleep: assert property (!(cmd_valid && hdr.ins == 8'hFA))
    else $error("sleep command issued");
  a_pending_len: assert property (rsp_valid && sw[15:8] == 8'h9F |-> sw[7:0] == 8'h0C)
    else $error("pending length wrong");
  a_get_resp_len: assert property (
    app_cmd && hdr.ins == 8'hC0 ##1 sw == 16'h9000 |-> rsp_len == $past(hdr.p3))
    else $error("fetch length wrong");
  a_nodata_len: assert property (
    app_cmd && hdr.ins inside {8'h04, 8'h44} && hdr.p3 != 8'h00 |=> sw != 16'h9000)
    else $error("no-data length accepted");
  a_status_hold: assert property (!cmd_valid |=> $stable(sw) && $stable(rsp_data))
    else $error("status changed without command");
  c_disable: cover property (app_cmd && hdr.ins == 8'h26 ##1 sw == 16'h9000);
  c_pending: cover property (rsp_valid && sw[15:8] == 8'h9F);
  c_unblock: cover property (app_cmd && hdr.ins == 8'h2C ##1 sw == 16'h9000);
endmodule

// ==== test/tb_card_cmd_secret_code_engine.sv ====
`timescale 1ns/100ps
module tb_card_cmd_secret_code_engine;
  import ccsce_pkg::*;
  localparam logic [63:0] C1 = 64'h0123456789ABCDEF;
  localparam logic [63:0] C2 = 64'h1122334455667788;
  localparam logic [63:0] K1 = 64'hA5A5A5A55A5A5A5A;
  localparam logic [63:0] K2 = 64'h0F0F0F0FF0F0F0F0;
  localparam logic [63:0] NC = 64'h3333444455556666;
  localparam logic [95:0] AR = 96'hFEDCBA987654321000112233;
  localparam logic [7:0] RSV [6] = '{8'h10, 8'h1E, 8'h2A, 8'hD0, 8'hC4, 8'hBC};
  logic [31:0] scratch;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic app_dir = 1'b0;
  logic fsel = 1'b1;
  logic facc = 1'b0;
  logic en1;
  logic ver1;
  logic finv;
  logic [15:0] boff;
  int bad_count = 0;
  int checked = 0;
  ccsce_if link ();
  ccsce_card ccsce_card_i (.pclk(pclk), .presetn(presetn), .link(link),
    .app_dir_current(app_dir), .file_selected(fsel), .file_access_ok(facc),
    .first_code_init(C1), .second_code_init(C2), .unblock_key_first(K1),
    .unblock_key_second(K2), .auth_result(AR), .first_code_enabled(en1),
    .first_code_verified(ver1), .file_invalidated(finv), .binary_offset(boff));
  ccsce_handset ccsce_handset_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  ccsce_checker ccsce_checker_i (.pclk(pclk), .presetn(presetn), .cmd_valid(link.cmd_valid),
    .cmd_ready(link.cmd_ready), .hdr(link.hdr), .cmd_data(link.cmd_data),
    .rsp_valid(link.rsp_valid), .sw(link.sw), .rsp_data(link.rsp_data),
    .rsp_len(link.rsp_len));
  initial
  begin
    forever #25 pclk = ~pclk;
  end
  task automatic wrap_up;
    if (bad_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      bad_count++;
      wrap_up();
    end
  endtask
  // command through registers, wait done, compare status word
  task automatic cmd(input logic [39:0] h, input logic [63:0] pc, input logic [63:0] nc,
    input logic [15:0] e);
    logic [31:0] r;
    int n;
    apb(1'b1, 12'h000, h[39:8], r);
    apb(1'b1, 12'h008, pc[63:32], r);
    apb(1'b1, 12'h008, pc[31:0], r);
    apb(1'b1, 12'h004, nc[63:32], r);
    apb(1'b1, 12'h004, nc[31:0], r);
    apb(1'b1, 12'h00C, {16'h0000, h[7:0], 8'h01}, r);
    r = 32'h00000000;
    n = 0;
    while (r[1] !== 1'b1 && n < 20)
    begin
      apb(1'b0, 12'h010, 32'h00000000, r);
      n++;
    end
    if (r[1] !== 1'b1)
    begin
      bad_count++;
      wrap_up();
    end
    apb(1'b0, 12'h014, 32'h00000000, r);
    chk(r, {16'h0000, e});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h00000000, r);
    chk(r, e);
  endtask
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    cmd(40'hB026000108, C1, NC, 16'h6E00);
    chk({31'h0, en1}, 32'h1);
    foreach (RSV[i])
      cmd({8'hA0, RSV[i], 24'h000008}, C1, NC, 16'h6D00);
    cmd(40'hA020000108, C1, NC, 16'h9000);
    cmd(40'hA020000208, C1, NC, 16'h9804);
    cmd(40'hA020000208, C2, NC, 16'h9000);
    cmd(40'hA026000108, ~C1, NC, 16'h9804);
    chk({31'h0, en1}, 32'h1);
    cmd(40'hA026000108, C1, NC, 16'h9000);
    chk({31'h0, en1}, 32'h0);
    cmd(40'hA026000108, C1, NC, 16'h9808);
    cmd(40'hA028000108, ~C1, NC, 16'h9804);
    cmd(40'hA028000108, ~C1, NC, 16'h9804);
    cmd(40'hA028000108, C1, NC, 16'h9000);
    chk({31'h0, en1}, 32'h1);
    cmd(40'hA028000108, C1, NC, 16'h9808);
    repeat (3) cmd(40'hA026000108, ~C1, NC, 16'h9804);
    cmd(40'hA026000108, C1, NC, 16'h9840);
    cmd(40'hA028000108, C1, NC, 16'h9840);
    cmd(40'hA02C000010, ~K1, NC, 16'h9804);
    cmd(40'hA026000108, C1, NC, 16'h9840);
    cmd(40'hA02C000010, K1, NC, 16'h9000);
    chk({30'h0, en1, ver1}, 32'h3);
    cmd(40'hA020000108, C1, NC, 16'h9804);
    cmd(40'hA020000108, NC, C1, 16'h9000);
    cmd(40'hA024000110, NC, C1, 16'h9000);
    cmd(40'hA020000108, C1, NC, 16'h9000);
    cmd(40'hA02C000210, K2, C2, 16'h9000);
    repeat (10) cmd(40'hA02C000210, ~K2, C2, 16'h9804);
    cmd(40'hA02C000210, K2, C2, 16'h9840);
    cmd(40'hA004000000, C1, NC, 16'h9804);
    facc <= 1'b1;
    fsel <= 1'b0;
    cmd(40'hA004000000, C1, NC, 16'h9400);
    fsel <= 1'b1;
    cmd(40'hA004000001, C1, NC, 16'h6700);
    cmd(40'hA004000000, C1, NC, 16'h9000);
    chk({31'h0, finv}, 32'h1);
    cmd(40'hA0B0000010, C1, NC, 16'h9810);
    cmd(40'hA044000000, C1, NC, 16'h9000);
    chk({31'h0, finv}, 32'h0);
    cmd(40'hA0B012FF00, C1, NC, 16'h9000);
    chk({16'h0000, boff}, 32'h000012FF);
    cmd(40'hA088000010, C1, NC, 16'h9804);
    app_dir <= 1'b1;
    cmd(40'hA088000010, C1, NC, 16'h9F0C);
    cmd(40'hA0C000000C, C1, NC, 16'h9000);
    rd(12'h018, AR[31:0]);
    rd(12'h01C, AR[63:32]);
    rd(12'h020, AR[95:64]);
    apb(1'b1, 12'h000, 32'hA0FA0000, scratch);
    apb(1'b1, 12'h00C, 32'h00000001, scratch);
    // idle, not done, last fetch length still shown
    rd(12'h010, {24'h000000, 6'h0C, 2'h0});
    rd(12'h100, 32'h00000000);
    chk({31'h0, pslverr}, 32'h0);
    wrap_up();
  end
endmodule
